// File: core/smrc_core.v
/*
 * Supply mode and reset control with its serial slave: power-on and command
 * reset, stand-by entry and wake-up from the sense multiplexer select field,
 * limp-home handling and the first reply after any reset.
 * Assumes all serial pins, the limp-home pin, the channel input pins and the
 * supply-good levels are asynchronous to mclk; the serial clock is far slower
 * than mclk and is sampled, not used as a clock.
 */
`timescale 1ns/10ps
`include "smrc_defines.vh"

module smrc_core #(
    parameter CHANNELS        = 6,
    parameter WAKE_CYCLES     = ((`SMRC_POWERON_WAKE_TIME_US * 1000) + `SMRC_CLK_PERIOD_NS - 1) / `SMRC_CLK_PERIOD_NS,
    parameter DELAY_CYCLES    = (`SMRC_TRANSFER_DELAY_TIME_NS + `SMRC_CLK_PERIOD_NS - 1) / `SMRC_CLK_PERIOD_NS,
    parameter CNT_WIDTH       = 13
) (
    input  wire                mclk,
    input  wire                reset,
    input  wire                logicSupplyOk,
    input  wire                switchSupplyOk,
    input  wire                limpHomeInput,
    input  wire [CHANNELS-1:0] channelInputPin,
    input  wire                spiCs_n,
    input  wire                spiSclk,
    input  wire                spiMosi,
    output reg                 spiMiso,
    output wire                spiMisoEn,
    output reg  [CHANNELS-1:0] channelOutput,
    output reg  [2:0]          senseMuxSelect,
    output reg                 senseEnable,
    output reg                 standbyFlag,
    output reg                 limpHomeActive,
    output reg                 registerReset,
    output reg                 thermalLatchClear,
    output reg                 spiReady,
    output reg                 transferErrorFlag
);

    localparam [CNT_WIDTH-1:0] WAKE_LOAD  = WAKE_CYCLES[CNT_WIDTH-1:0];
    localparam [CNT_WIDTH-1:0] DELAY_LOAD = DELAY_CYCLES[CNT_WIDTH-1:0];

    wire [CHANNELS+5:0] syncBus;
    wire                supplySync;
    wire                switchSync;
    wire                limpSync;
    wire                csSync_n;
    wire                sclkSync;
    wire                mosiSync;
    wire [CHANNELS-1:0] pinSync;

    reg                 limpPrev_reg;
    reg                 csPrev_reg;
    reg                 sclkPrev_reg;
    reg  [7:0]          rxShift_reg;
    reg  [7:0]          txShift_reg;
    reg                 lastBit_reg;
    reg  [5:0]          bitCount_reg;
    reg  [CHANNELS-1:0] outReg_reg;
    reg                 ctl_reg;
    reg  [2:0]          readSel_reg;
    reg                 swRst_reg;
    reg  [CNT_WIDTH-1:0] waitCount_reg;

    wire                csFall;
    wire                csRise;
    wire                sclkRise;
    wire                sclkFall;
    wire                frameGood;
    wire                frameDone;
    wire                writeFrame;
    wire [2:0]          frameSel;
    wire                clearRegs;
    wire                standbyNext;
    wire                terSet;
    wire                terClear;
    wire [7:0]          replyByte;

    // All pins cross into mclk together through one synchroniser.
    smrc_sync #(
        .WIDTH   (CHANNELS + 6)
    ) u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .asyncIn ({channelInputPin, spiMosi, spiSclk, ~spiCs_n, limpHomeInput, switchSupplyOk, logicSupplyOk}),
        .syncOut (syncBus)
    );

    assign supplySync = syncBus[0];
    assign switchSync = syncBus[1];
    assign limpSync   = syncBus[2];
    // Chip select crosses inverted, so the cleared synchroniser reads as deselected and no false edge follows reset.
    assign csSync_n   = ~syncBus[3];
    assign sclkSync   = syncBus[4];
    assign mosiSync   = syncBus[5];
    assign pinSync    = syncBus[CHANNELS+5:6];

    // Read data for a register code; also used to build the reply byte.
    function [3:0] readData;
        input [2:0]          sel;
        input [CHANNELS-1:0] outBits;
        input                stb;
        input                ctl;
        input                limp;
        input [2:0]          mux;
        reg   [7:0]          wide;
        begin
            wide = 8'h00;
            wide[CHANNELS-1:0] = outBits;
            case (sel)
                `SMRC_SEL_OUT_LO: readData = wide[3:0];
                `SMRC_SEL_OUT_HI: readData = wide[7:4];
                `SMRC_SEL_HARDWARE_CONFIG_REGISTER:   readData = {2'h0, stb, ctl};
                `SMRC_SEL_DCR:    readData = {limp, mux};
                default:          readData = 4'h0;
            endcase
        end
    endfunction

    // Edges of the synchronised serial pins; each comes from stage two and a history flop.
    assign csFall   = csPrev_reg & ~csSync_n;
    assign csRise   = ~csPrev_reg & csSync_n;
    assign sclkRise = ~csSync_n & ~sclkPrev_reg & sclkSync;
    assign sclkFall = ~csSync_n & sclkPrev_reg & ~sclkSync;

    // A frame is whole when a multiple of eight bits from 8 to 56 was clocked; longer
    // frames are daisy-chained and the last eight bits are the own command.
    assign frameDone  = csRise & spiReady;
    assign frameGood  = (bitCount_reg != 6'h00) && (bitCount_reg[2:0] == 3'h0);
    assign writeFrame = rxShift_reg[`SMRC_WRITE_BIT];
    assign frameSel   = rxShift_reg[`SMRC_SEL_HI:`SMRC_SEL_LO];

    // Power-on, loss of the logic supply and the command reset clear the bank.
    assign clearRegs = swRst_reg | ~supplySync;

    // Stand-by is decided by the select field and the limp-home pin, never by the channel pins.
    assign standbyNext = (senseMuxSelect == `SMRC_MUX_STANDBY) & ~limpSync;

    // Any reset source or a broken frame sets the error flag; a clean frame that
    // carried the flag out clears it. Set wins when both coincide.
    assign terSet   = clearRegs | (limpSync & ~limpPrev_reg) | (frameDone & ~frameGood);
    assign terClear = frameDone & frameGood;

    assign replyByte = {transferErrorFlag, readSel_reg,
                        readData(readSel_reg, outReg_reg, standbyFlag, ctl_reg, limpSync, senseMuxSelect)};

    // The serial output is driven only while chip select is low.
    assign spiMisoEn = ~csSync_n;

    // Pin history flops used by the edge detectors.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            limpPrev_reg    <= 1'b0;
            csPrev_reg      <= 1'b1;
            sclkPrev_reg    <= 1'b0;
        end else begin
            limpPrev_reg    <= limpSync;
            csPrev_reg      <= csSync_n;
            sclkPrev_reg    <= sclkSync;
        end
    end

    // Serial shifter: sample on the rising edge, shift out on the falling edge.
    // The sampled bit enters the transmit register so data passes to the next
    // device in a chain eight bits later; it needs no switch supply.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rxShift_reg  <= 8'h00;
            txShift_reg  <= 8'h00;
            lastBit_reg  <= 1'b0;
            bitCount_reg <= 6'h00;
            spiMiso      <= 1'b0;
        end else if (csFall) begin
            txShift_reg  <= replyByte;
            spiMiso      <= replyByte[7];
            bitCount_reg <= 6'h00;
        end else if (sclkRise) begin
            rxShift_reg  <= {rxShift_reg[6:0], mosiSync};
            lastBit_reg  <= mosiSync;
            if (bitCount_reg != 6'h3f) begin
                bitCount_reg <= bitCount_reg + 6'h01;
            end
        end else if (sclkFall) begin
            txShift_reg  <= {txShift_reg[6:0], lastBit_reg};
            spiMiso      <= txShift_reg[6];
        end
    end

    // Register bank and the self-clearing reset command.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            outReg_reg     <= `SMRC_OUT_RESET;
            ctl_reg        <= `SMRC_CTL_RESET;
            senseMuxSelect <= `SMRC_MUX_RESET;
            readSel_reg    <= `SMRC_SEL_RESET;
            swRst_reg      <= 1'b0;
        end else if (clearRegs) begin
            outReg_reg     <= `SMRC_OUT_RESET;
            ctl_reg        <= `SMRC_CTL_RESET;
            senseMuxSelect <= `SMRC_MUX_RESET;
            readSel_reg    <= `SMRC_SEL_RESET;
            swRst_reg      <= 1'b0;
        end else if (limpSync) begin
            outReg_reg     <= `SMRC_OUT_RESET;
            ctl_reg        <= `SMRC_CTL_RESET;
            senseMuxSelect <= `SMRC_MUX_RESET;
            if (frameDone && frameGood && !writeFrame) begin
                readSel_reg <= frameSel;
            end
        end else if (frameDone && frameGood) begin
            if (!writeFrame) begin
                readSel_reg <= frameSel;
            end else begin
                case (frameSel)
                    `SMRC_SEL_OUT_LO: outReg_reg[3:0] <= rxShift_reg[3:0];
                    `SMRC_SEL_OUT_HI: outReg_reg[CHANNELS-1:4] <= rxShift_reg[CHANNELS-5:0];
                    `SMRC_SEL_HARDWARE_CONFIG_REGISTER: begin
                        ctl_reg   <= rxShift_reg[`SMRC_HARDWARE_CONFIG_REGISTER_CTL_BIT];
                        swRst_reg <= rxShift_reg[`SMRC_HARDWARE_CONFIG_REGISTER_RST_BIT];
                    end
                    `SMRC_SEL_DCR:    senseMuxSelect <= rxShift_reg[2:0];
                    default:          swRst_reg <= 1'b0;
                endcase
            end
        end
    end

    // Access gate: wake time after the supply rises, transfer delay after a
    // command reset. Frames ending inside the wait are dropped, so a master
    // that ignores the wait loses its command rather than half-applying it.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            waitCount_reg <= WAKE_LOAD;
            spiReady      <= 1'b0;
        end else begin
            if (!supplySync) begin
                waitCount_reg <= WAKE_LOAD;
            end else if (swRst_reg) begin
                waitCount_reg <= DELAY_LOAD;
            end else if (waitCount_reg != {CNT_WIDTH{1'b0}}) begin
                waitCount_reg <= waitCount_reg - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
            spiReady <= supplySync & ~swRst_reg & (waitCount_reg == {CNT_WIDTH{1'b0}});
        end
    end

    // Status, error flag and mode outputs.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            transferErrorFlag <= 1'b1;
            standbyFlag       <= 1'b0;
            limpHomeActive    <= 1'b0;
            senseEnable       <= 1'b0;
            registerReset     <= 1'b1;
            thermalLatchClear <= 1'b0;
        end else begin
            transferErrorFlag <= terSet | (transferErrorFlag & ~terClear);
            standbyFlag       <= standbyNext;
            limpHomeActive    <= limpSync;
            senseEnable       <= supplySync & ~limpSync & ~standbyNext;
            registerReset     <= clearRegs | limpSync;
            thermalLatchClear <= standbyNext & ~standbyFlag;
        end
    end

    // Power stage drive. No reset term other than the asynchronous start value:
    // register resets only change the bank, which then steers the outputs.
    // In limp-home each channel follows its own pin, with or without logic supply.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            channelOutput <= {CHANNELS{1'b0}};
        end else if (!switchSync) begin
            channelOutput <= {CHANNELS{1'b0}};
        end else if (limpSync) begin
            channelOutput <= pinSync;
        end else if (ctl_reg) begin
            channelOutput <= outReg_reg & pinSync;
        end else begin
            channelOutput <= outReg_reg | pinSync;
        end
    end

endmodule // smrc_core

// File: core/smrc_defines.vh
/*
 * Shared constants of the supply mode and reset control block: frame layout,
 * register codes, field positions, reset values and timing figures.
 * Assumes it is included by bare name into each design file that needs it.
 */
`ifndef SMRC_DEFINES_VH
`define SMRC_DEFINES_VH

// Serial frame layout: bit 7 write/read, bits 6:4 register code, bits 3:0 data.
`define SMRC_FRAME_BITS      8
`define SMRC_WRITE_BIT       7
`define SMRC_SEL_HI          6
`define SMRC_SEL_LO          4

// Register codes {bank, address}.
`define SMRC_SEL_OUT_LO      3'h0
`define SMRC_SEL_OUT_HI      3'h1
`define SMRC_SEL_HARDWARE_CONFIG_REGISTER        3'h6
`define SMRC_SEL_DCR         3'h7

// Field positions.
`define SMRC_HARDWARE_CONFIG_REGISTER_CTL_BIT    0
`define SMRC_HARDWARE_CONFIG_REGISTER_RST_BIT    1
`define SMRC_HARDWARE_CONFIG_REGISTER_STB_BIT    1
`define SMRC_DCR_LIMP_BIT    3

// Reset values and the stand-by code of the sense multiplexer select field.
`define SMRC_MUX_STANDBY     3'h7
`define SMRC_MUX_RESET       3'h7
`define SMRC_OUT_RESET       6'h00
`define SMRC_CTL_RESET       1'h0
`define SMRC_SEL_RESET       3'h0

// Timing figures in their own units and the clock period.
`define SMRC_CLK_PERIOD_NS           50
`define SMRC_POWERON_WAKE_TIME_US    200
`define SMRC_TRANSFER_DELAY_TIME_NS  1000

`endif

// File: core/smrc_sync.v
/*
 * Two flip-flop synchroniser for a group of asynchronous level inputs.
 * Assumes its inputs come from pins outside the mclk domain.
 */
`timescale 1ns/10ps
module smrc_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_reg;

    // The first stage feeds only the second stage, to let metastability settle.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage1_reg <= {WIDTH{1'b0}};
            syncOut    <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule // smrc_sync

// File: dv/smrc_core_monitor.sv
/* Concurrent checks on the mode and reset outputs of smrc_core.
   Assumes it is bound to smrc_core and sees that module's ports only. */
`timescale 1ns/10ps
module smrc_core_monitor #(
    parameter CHANNELS = 6
) (
    input wire                mclk,
    input wire                reset,
    input wire                logicSupplyOk,
    input wire                switchSupplyOk,
    input wire [CHANNELS-1:0] channelInputPin,
    input wire [CHANNELS-1:0] channelOutput,
    input wire [2:0]          senseMuxSelect,
    input wire                senseEnable,
    input wire                standbyFlag,
    input wire                limpHomeActive,
    input wire                registerReset,
    input wire                thermalLatchClear,
    input wire                spiReady,
    input wire                transferErrorFlag
);
    // All checks share the core clock; windows of five cycles absorb the synchroniser lag.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    standby_set_a: assert property ((senseMuxSelect == 3'h7 && !limpHomeActive)[*5] |-> standbyFlag)
        else $error("standby flag missing");
    standby_cause_a: assert property (standbyFlag |-> $past(senseMuxSelect) == 3'h7)
        else $error("standby flag without standby code");
    latch_entry_a: assert property ($rose(standbyFlag) |-> (thermalLatchClear || $past(thermalLatchClear))
        or ##1 thermalLatchClear)
        else $error("no latch clear on standby entry");
    latch_pulse_a: assert property (thermalLatchClear |=> !thermalLatchClear)
        else $error("latch clear longer than one cycle");
    limp_sense_a: assert property (limpHomeActive && $past(limpHomeActive) |-> !senseEnable)
        else $error("sense enabled in limp home");
    limp_follow_a: assert property ((limpHomeActive && switchSupplyOk && $stable(channelInputPin))[*5]
        |-> channelOutput == channelInputPin)
        else $error("outputs do not follow pins in limp home");
    limp_hold_a: assert property (limpHomeActive[*3] |-> registerReset && senseMuxSelect == 3'h7)
        else $error("registers not held in limp home");
    // A supply loss holds the bank in reset for as long as it lasts, so only a command reset with the supply up counts.
    rst_single_a: assert property ($rose(registerReset) && !limpHomeActive && logicSupplyOk
        && $past(logicSupplyOk) && $past(logicSupplyOk, 2) && $past(logicSupplyOk, 3)
        |=> !registerReset || limpHomeActive)
        else $error("reset command repeats");
    rst_wait_a: assert property ($rose(registerReset) ##1 (!registerReset && !limpHomeActive)
        |-> (!spiReady && transferErrorFlag)[*8])
        else $error("serial port open too early after reset command");
endmodule // smrc_core_monitor

bind smrc_core smrc_core_monitor #(.CHANNELS(CHANNELS)) u_smrc_core_monitor (
    .mclk(mclk), .reset(reset), .logicSupplyOk(logicSupplyOk), .switchSupplyOk(switchSupplyOk),
    .channelInputPin(channelInputPin),
    .channelOutput(channelOutput), .senseMuxSelect(senseMuxSelect), .senseEnable(senseEnable),
    .standbyFlag(standbyFlag), .limpHomeActive(limpHomeActive), .registerReset(registerReset),
    .thermalLatchClear(thermalLatchClear), .spiReady(spiReady), .transferErrorFlag(transferErrorFlag));

// File: dv/smrc_spi_master.sv
/* Serial master model: sends 8-bit frames MSB first in mode 0 with a 400 ns clock.
   Assumes the caller keeps frames apart; the reply byte is flagged by rxValid. */
`timescale 1ns/10ps
module smrc_spi_master (
    input  wire       mclk,
    input  wire       miso,
    input  wire       misoEn,
    output reg        csN,
    output reg        sclk,
    output reg        mosi,
    output reg  [7:0] rxByte,
    output reg        rxValid
);
    integer i;
    // The serial clock stands low between frames.
    initial begin
        csN = 1'b1; sclk = 1'b0; mosi = 1'b0; rxByte = 8'h00; rxValid = 1'b0;
    end
    // One half of the serial clock, four core cycles.
    task half;
        repeat (4) @(negedge mclk);
    endtask
    // A released output reads as unknown, so a missing drive never passes.
    task xfer(input [7:0] tx);
        begin
            @(negedge mclk); csN = 1'b0; mosi = tx[7]; half;
            for (i = 7; i >= 0; i = i - 1) begin
                sclk = 1'b1; rxByte[i] = misoEn ? miso : 1'bx; half;
                sclk = 1'b0; mosi = (i > 0) ? tx[(i + 7) % 8] : ~tx[0]; half;
            end
            csN = 1'b1; rxValid = 1'b1; @(negedge mclk); rxValid = 1'b0;
            repeat (6) @(negedge mclk); mosi = ~mosi;
        end
    endtask
endmodule // smrc_spi_master

// File: dv/tb.sv
/* Self-checking bench for smrc_core: replies go through a queue, levels are checked directly.
   Assumes a short wake count of 20 cycles and the serial master model beside the core. */
`timescale 1ns/10ps
module tb;
    reg        mclk, reset, logicSupplyOk, switchSupplyOk, limpHomeInput;
    reg  [5:0] channelInputPin;
    reg  [2:0] mux;
    reg  [3:0] dat;
    integer    n_mismatch, comparisons, seed, k;
    logic [7:0] expQ[$];
    wire       spiCs_n, spiSclk, spiMosi, spiMiso, spiMisoEn, spiReady, rxValid;
    wire [7:0] rxByte;
    wire [5:0] channelOutput;
    wire [2:0] senseMuxSelect;
    wire       senseEnable, standbyFlag;
    smrc_core #(.WAKE_CYCLES(20)) u_smrc_core (.mclk(mclk), .reset(reset), .logicSupplyOk(logicSupplyOk),
        .switchSupplyOk(switchSupplyOk), .limpHomeInput(limpHomeInput), .channelInputPin(channelInputPin),
        .spiCs_n(spiCs_n), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEn(spiMisoEn),
        .channelOutput(channelOutput), .senseMuxSelect(senseMuxSelect), .senseEnable(senseEnable),
        .standbyFlag(standbyFlag), .limpHomeActive(), .registerReset(), .thermalLatchClear(),
        .spiReady(spiReady), .transferErrorFlag());
    smrc_spi_master u_smrc_spi_master (.mclk(mclk), .miso(spiMiso), .misoEn(spiMisoEn), .csN(spiCs_n),
        .sclk(spiSclk), .mosi(spiMosi), .rxByte(rxByte), .rxValid(rxValid));
    // Core clock at 20 MHz.
    always #25 mclk = ~mclk;
    // An all-unknown note marks a reply whose content is not fixed.
    task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Each reply is compared with the oldest note of the driver unless that note is all-unknown.
    always @(posedge rxValid) begin
        if (expQ.size() == 0) check8("unexpected reply", 8'h00, 8'hff);
        else if (expQ[0] === 8'hxx) void'(expQ.pop_front());
        else check8("reply", expQ.pop_front(), rxByte);
    end
    task send(input [7:0] tx, input logic [7:0] exp);
        expQ.push_back(exp);
        u_smrc_spi_master.xfer(tx);
    endtask
    // Bounded wait for the port to open, with slack for the delay after it.
    task waitReady;
        for (k = 0; k < 400 && spiReady !== 1'b1; k = k + 1) @(negedge mclk);
        if (spiReady !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end else begin
            repeat (4) @(negedge mclk);
        end
    endtask
    initial begin
        mclk = 1'b0; reset = 1'b1; logicSupplyOk = 1'b1; switchSupplyOk = 1'b0;
        limpHomeInput = 1'b0; channelInputPin = 6'h00; n_mismatch = 0; comparisons = 0;
        seed = $urandom(32'hcdac655f);
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        waitReady;
        check8("standby", 8'h01, {7'h00, standbyFlag});
        send(8'h00, 8'h80);
        switchSupplyOk = 1'b1;
        mux = 3'($urandom_range(0, 6));
        dat = 4'($urandom_range(1, 15));
        send({5'h1e, mux}, 8'h00);
        check8("mux", {5'h00, mux}, {5'h00, senseMuxSelect});
        check8("awake", 8'h01, {6'h00, standbyFlag, senseEnable});
        send({4'h8, dat}, 8'h00);
        check8("outputs", {4'h0, dat}, {4'h0, channelOutput[3:0]});
        // Upper channels on, then the gating mode: each channel needs its bit and its pin.
        send(8'h93, {4'h0, dat});
        send(8'he1, {4'h0, dat});
        channelInputPin = 6'($urandom);
        repeat (5) @(negedge mclk);
        check8("gated outputs", {2'h0, 2'h3, dat} & {2'h0, channelInputPin}, {2'h0, channelOutput});
        channelInputPin = 6'h00;
        send(8'h10, {4'h0, dat});
        send(8'he0, 8'h13);
        send(8'h70, 8'h13);
        send(8'h00, {5'h0e, mux});
        send(8'h60, {4'h0, dat});
        send(8'hf7, 8'h60);
        for (k = 0; k < 4; k = k + 1) begin
            channelInputPin = 6'($urandom);
            repeat (5) @(negedge mclk);
            check8("standby pins", 8'h01, {7'h00, standbyFlag});
        end
        channelInputPin = 6'h00;
        send(8'h60, 8'h62);
        send(8'h60, 8'h62);
        send(8'he2, 8'h62);
        waitReady;
        check8("mux after command", 8'h07, {5'h00, senseMuxSelect});
        check8("outputs after command", 8'h00, {2'h0, channelOutput});
        send(8'h00, 8'h80);
        send(8'h85, 8'h00);
        // A short loss of the logic supply must clear the bank like a power-on.
        logicSupplyOk = 1'b0;
        repeat (4) @(negedge mclk);
        logicSupplyOk = 1'b1;
        waitReady;
        send(8'h00, 8'h80);
        limpHomeInput = 1'b1;
        channelInputPin = 6'($urandom);
        repeat (10) @(negedge mclk);
        check8("limp outputs", {2'h0, channelInputPin}, {2'h0, channelOutput});
        check8("limp sense", 8'h00, {7'h00, senseEnable});
        waitReady;
        send(8'h70, 8'h80);
        send(8'hf2, 8'h7f);
        check8("limp mux", 8'h07, {5'h00, senseMuxSelect});
        // Limp-home must keep the channels on their pins with the logic supply gone.
        logicSupplyOk = 1'b0;
        channelInputPin = 6'($urandom);
        repeat (10) @(negedge mclk);
        check8("limp no supply", {2'h0, channelInputPin}, {2'h0, channelOutput});
        logicSupplyOk = 1'b1;
        repeat (10) @(negedge mclk);
        stop_test;
    end
endmodule // tb
